// ==== common/tcrs_pkg.sv ====
// Purpose: shared constants for the timer read resynchronisation block
// Assumes: 32-bit APB, one word per register
// Notes: offsets are byte addresses
package tcrs_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] SIC_OFF = 8'h00; // sync_interface_control
	localparam logic [7:0] TCV_OFF = 8'h04; // timer_counter_value
	localparam logic [7:0] CV1_OFF = 8'h08; // capture_value_one
	localparam logic [7:0] CV2_OFF = 8'h0c; // capture_value_two
	localparam logic [7:0] WCV_OFF = 8'h10; // watchdog_counter_value
	localparam logic [7:0] STS_OFF = 8'h14; // resync status
	localparam logic [7:0] CTL_OFF = 8'h18; // timer control
	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int POSTED_BIT = 2;
	localparam int RDMODE_BIT = 3;
	localparam int RUN_BIT = 0;
	localparam int TSTALE_BIT = 0;
	localparam int WSTALE_BIT = 1;
	localparam logic POSTED_RST = 1'b1;
	localparam logic RDMODE_RST = 1'b0;
	localparam logic RUN_RST = 1'b0;
	// ------------------------------------------------------------
	// resume wait: interface cycles before the functional tick
	// ------------------------------------------------------------
	localparam logic [1:0] RESUME_IF_CYCLES = 2'h2;
	localparam logic [3:0] FCLK_DIV_RST = 4'h3; // functional tick every 4 cycles
	// resync state of the deferred copies
	typedef enum logic [1:0] {
		TCRS_SLEEP = 2'b00,
		TCRS_WAITIF = 2'b01,
		TCRS_WAITFN = 2'b10,
		TCRS_SYNCED = 2'b11
	} tcrs_sync_e;
endpackage : tcrs_pkg

// ==== sim/timer_counter_read_resync_test.sv ====
// Purpose: self-checking bench for the timer read resynchronisation block
// Assumes: APB answers one access cycle after setup; the timer counter holds while run is clear
// Notes: a scoreboard queue pairs every APB transfer with its expected answer
`timescale 1ns/1ps
module timer_counter_read_resync_test;
	logic MCLK = 1'b0;
	logic SRST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic IF_CLK_ACTIVE = 1'b0;
	logic CAPTURE_IN = 1'b0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic TIMER_STALE;
	logic [33:0] exp_q[$]; // {is_read, slverr, data}
	logic [31:0] seed = 32'h00010b1b;
	logic [31:0] x_val;
	logic [31:0] y_val;
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	tcrs_timer i_tcrs_timer (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .IF_CLK_ACTIVE(IF_CLK_ACTIVE), .CAPTURE_IN(CAPTURE_IN),
		.TIMER_STALE(TIMER_STALE));
	// 40 MHz clock
	always #12.5 MCLK = ~MCLK;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	// request held until pready is sampled high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		n = 0;
		exp_q.push_back({~w, e});
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge MCLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge MCLK);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 33'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		xfer(1'b0, a, 32'h0, e);
	endtask : rd
	task automatic capture_edge;
		CAPTURE_IN <= 1'b1;
		repeat (6) @(posedge MCLK);
		CAPTURE_IN <= 1'b0;
		repeat (6) @(posedge MCLK);
	endtask : capture_edge
	// ------------------------------------------------------------
	// monitor: oldest note against each answer
	// ------------------------------------------------------------
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			fails++;
			summarize();
		end
		if (PREADY === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected pready", 32'h1, 32'h0);
			end else begin
				if (exp_q[0][33]) begin
					chk("prdata", PRDATA, exp_q[0][31:0]);
				end
				chk("pslverr", {31'h0, PSLVERR}, {31'h0, exp_q[0][32]});
				void'(exp_q.pop_front());
			end
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int n;
		repeat (12) @(posedge MCLK);
		SRST <= 1'b0;
		@(posedge MCLK);
		chk("stale after reset", {31'h0, TIMER_STALE}, 32'h1);
		rd(tcrs_pkg::SIC_OFF, 33'h4);
		rd(tcrs_pkg::STS_OFF, 33'h3);
		rd(8'h1c, 33'h100000000);
		// unmapped write is refused with an error and changes nothing
		xfer(1'b1, 8'h20, 32'hffffffff, 33'h100000000);
		seed = lfsr(seed);
		x_val = seed;
		wr(tcrs_pkg::TCV_OFF, x_val);
		rd(tcrs_pkg::TCV_OFF, 33'h0);
		wr(tcrs_pkg::SIC_OFF, 32'h8);
		rd(tcrs_pkg::SIC_OFF, 33'h0);
		rd(tcrs_pkg::TCV_OFF, {1'b0, x_val});
		rd(tcrs_pkg::WCV_OFF, 33'h0);
		rd(tcrs_pkg::STS_OFF, 33'h2);
		capture_edge();
		capture_edge();
		rd(tcrs_pkg::CV1_OFF, {1'b0, x_val});
		rd(tcrs_pkg::CV2_OFF, {1'b0, x_val});
		wr(tcrs_pkg::SIC_OFF, 32'h0);
		rd(tcrs_pkg::TCV_OFF, 33'h0);
		wr(tcrs_pkg::SIC_OFF, 32'h4);
		// wake the interface clock and wait for the copies to settle
		IF_CLK_ACTIVE <= 1'b1;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (TIMER_STALE !== 1'b0 && n < 30);
		chk("stale after wake", {31'h0, TIMER_STALE}, 32'h0);
		// copies may not settle before two interface cycles and one tick
		chk("wake wait", {31'h0, n >= 3}, 32'h1);
		repeat (4) @(posedge MCLK);
		rd(tcrs_pkg::TCV_OFF, {1'b0, x_val});
		rd(tcrs_pkg::CV2_OFF, {1'b0, x_val});
		rd(tcrs_pkg::STS_OFF, 33'h0);
		// stop the interface again: copies freeze, live read still exact
		IF_CLK_ACTIVE <= 1'b0;
		repeat (4) @(posedge MCLK);
		seed = lfsr(seed);
		y_val = seed;
		wr(tcrs_pkg::TCV_OFF, y_val);
		rd(tcrs_pkg::TCV_OFF, {1'b0, x_val});
		wr(tcrs_pkg::SIC_OFF, 32'h8);
		rd(tcrs_pkg::TCV_OFF, {1'b0, y_val});
		// back to back random live loads and reads
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(tcrs_pkg::TCV_OFF, seed);
			rd(tcrs_pkg::TCV_OFF, {1'b0, seed});
		end
		// run bit reads back as written; left last so counting spoils no check
		wr(tcrs_pkg::CTL_OFF, 32'h1);
		rd(tcrs_pkg::CTL_OFF, 33'h1);
		wr(tcrs_pkg::CTL_OFF, 32'h0);
		rd(tcrs_pkg::CTL_OFF, 33'h0);
		repeat (4) @(posedge MCLK);
		chk("queue drained", exp_q.size(), 32'h0);
		summarize();
	end
endmodule : timer_counter_read_resync_test

// ==== verilog/tcrs_timer.sv ====
// Purpose: general timer and watchdog counters read over APB with deferred copies
// Assumes: functional clock modelled as a tick derived from MCLK; interface clock
//          state arrives on IF_CLK_ACTIVE from the clock controller
// Notes:
// Operation
// - deferred reads may be stale after resume
// - non-deferred reads return live values only when readmode=1, else the deferred copy
// - live read when deferred=0 and readmode=1
// - read-mode bit write-only, reads zero
// - watchdog uses deferred synchronization only
// - watchdog has no sync mode control
// - watchdog read may be stale after resume
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module tcrs_timer #(
	parameter int CW = 32,
	parameter bit RDMODE_WO = 1'b1
) (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic IF_CLK_ACTIVE,
	input wire logic CAPTURE_IN,
	output logic TIMER_STALE
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic act_m_q, act_s_q, act_d_q;
	logic cap_m_q, cap_s_q, cap_d_q;
	logic act_rise;
	logic cap_rise;

	// three flops per pin; edges look only at the settled stages
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			act_m_q <= 1'b0;
			act_s_q <= 1'b0;
			act_d_q <= 1'b0;
			cap_m_q <= 1'b0;
			cap_s_q <= 1'b0;
			cap_d_q <= 1'b0;
		end else begin
			act_m_q <= IF_CLK_ACTIVE;
			act_s_q <= act_m_q;
			act_d_q <= act_s_q;
			cap_m_q <= CAPTURE_IN;
			cap_s_q <= cap_m_q;
			cap_d_q <= cap_s_q;
		end
	end
	assign act_rise = act_s_q & ~act_d_q;
	assign cap_rise = cap_s_q & ~cap_d_q;

	// ------------------------------------------------------------
	// functional tick and live counters
	// ------------------------------------------------------------
	logic [3:0] div_q;
	logic tick;
	logic [CW-1:0] tmr_cnt_q, wd_cnt_q, cap1_q, cap2_q;
	logic cap_sel_q;
	logic posted_q, rdmode_q, run_q;
	logic wr_acc;
	logic [7:0] addr_q;
	logic wr_q;

	// divider stands in for the slower functional clock
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			div_q <= tcrs_pkg::FCLK_DIV_RST;
		end else if (div_q == 4'h0) begin
			div_q <= tcrs_pkg::FCLK_DIV_RST;
		end else begin
			div_q <= div_q - 4'h1;
		end
	end
	assign tick = (div_q == 4'h0);

	// the access edge is the only edge where a write lands
	assign wr_acc = PSEL & PENABLE & PREADY & wr_q;

	// timer counter: software write loads, else counts on ticks when running
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tmr_cnt_q <= '0;
		end else if (wr_acc && addr_q == tcrs_pkg::TCV_OFF) begin
			tmr_cnt_q <= PWDATA[CW-1:0];
		end else if (tick && run_q) begin
			tmr_cnt_q <= tmr_cnt_q + 1'b1;
		end
	end

	// watchdog counter runs on every functional tick
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			wd_cnt_q <= '0;
		end else if (tick) begin
			wd_cnt_q <= wd_cnt_q + 1'b1;
		end
	end

	// captures alternate between the two capture registers
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			cap1_q <= '0;
			cap2_q <= '0;
			cap_sel_q <= 1'b0;
		end else if (cap_rise) begin
			cap_sel_q <= ~cap_sel_q;
			if (!cap_sel_q) begin
				cap1_q <= tmr_cnt_q;
			end else begin
				cap2_q <= tmr_cnt_q;
			end
		end
	end

	// ------------------------------------------------------------
	// deferred copies and resume tracking
	// ------------------------------------------------------------
	tcrs_pkg::tcrs_sync_e st_q, st_d;
	logic [1:0] wait_q;
	logic copy_en;
	logic [CW-1:0] tmr_cp_q, cv1_cp_q, cv2_cp_q, wd_cp_q;

	// after a resume the copies need two interface cycles and one tick
	always_comb begin
		st_d = st_q;
		case (st_q)
			tcrs_pkg::TCRS_SLEEP: begin
				if (act_rise) st_d = tcrs_pkg::TCRS_WAITIF;
			end
			tcrs_pkg::TCRS_WAITIF: begin
				if (!act_s_q) st_d = tcrs_pkg::TCRS_SLEEP;
				else if (wait_q == tcrs_pkg::RESUME_IF_CYCLES - 2'h1) begin
					st_d = tcrs_pkg::TCRS_WAITFN;
				end
			end
			tcrs_pkg::TCRS_WAITFN: begin
				if (!act_s_q) st_d = tcrs_pkg::TCRS_SLEEP;
				else if (tick) st_d = tcrs_pkg::TCRS_SYNCED;
			end
			tcrs_pkg::TCRS_SYNCED: begin
				if (!act_s_q) st_d = tcrs_pkg::TCRS_SLEEP;
			end
			default: st_d = tcrs_pkg::TCRS_SLEEP;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			st_q <= tcrs_pkg::TCRS_SLEEP;
			wait_q <= 2'h0;
		end else begin
			st_q <= st_d;
			wait_q <= (st_q == tcrs_pkg::TCRS_WAITIF) ? wait_q + 2'h1 : 2'h0;
		end
	end

	// copies move only on a tick once the interface side has settled
	assign copy_en = tick && (st_q == tcrs_pkg::TCRS_WAITFN || st_q == tcrs_pkg::TCRS_SYNCED);

	// frozen copies are what makes deferred reads stale after a restart
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tmr_cp_q <= '0;
			cv1_cp_q <= '0;
			cv2_cp_q <= '0;
			wd_cp_q <= '0;
		end else if (copy_en) begin
			tmr_cp_q <= tmr_cnt_q;
			cv1_cp_q <= cap1_q;
			cv2_cp_q <= cap2_q;
			wd_cp_q <= wd_cnt_q;
		end
	end

	// ------------------------------------------------------------
	// APB slave: one wait-free access, answer registered at setup
	// ------------------------------------------------------------
	logic live_rd;
	logic [31:0] rdat;
	logic mapped;

	assign live_rd = ~posted_q & rdmode_q;

	function automatic logic [31:0] tcrs_ext(input logic [CW-1:0] v);
		tcrs_ext = 32'(v);
	endfunction : tcrs_ext

	// read mux; watchdog always takes the deferred copy
	always_comb begin
		rdat = 32'h0000_0000;
		mapped = 1'b1;
		case (PADDR)
			tcrs_pkg::SIC_OFF: begin
				rdat[tcrs_pkg::POSTED_BIT] = posted_q;
				rdat[tcrs_pkg::RDMODE_BIT] = RDMODE_WO ? 1'b0 : rdmode_q;
			end
			tcrs_pkg::TCV_OFF: rdat = tcrs_ext(live_rd ? tmr_cnt_q : tmr_cp_q);
			tcrs_pkg::CV1_OFF: rdat = tcrs_ext(live_rd ? cap1_q : cv1_cp_q);
			tcrs_pkg::CV2_OFF: rdat = tcrs_ext(live_rd ? cap2_q : cv2_cp_q);
			tcrs_pkg::WCV_OFF: rdat = tcrs_ext(wd_cp_q);
			tcrs_pkg::STS_OFF: begin
				rdat[tcrs_pkg::TSTALE_BIT] = (st_q != tcrs_pkg::TCRS_SYNCED) & posted_q;
				rdat[tcrs_pkg::WSTALE_BIT] = (st_q != tcrs_pkg::TCRS_SYNCED);
			end
			tcrs_pkg::CTL_OFF: rdat[tcrs_pkg::RUN_BIT] = run_q;
			default: mapped = 1'b0;
		endcase
	end

	// setup cycle latches the answer so PREADY rises in the access cycle
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
			addr_q <= 8'h00;
			wr_q <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			PREADY <= 1'b1;
			PRDATA <= PWRITE ? 32'h0000_0000 : rdat;
			PSLVERR <= ~mapped;
			addr_q <= PADDR;
			wr_q <= PWRITE & mapped;
		end else begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
			wr_q <= 1'b0;
		end
	end

	// control bits; the watchdog has no mode bit anywhere
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			posted_q <= tcrs_pkg::POSTED_RST;
			rdmode_q <= tcrs_pkg::RDMODE_RST;
			run_q <= tcrs_pkg::RUN_RST;
		end else if (wr_acc && addr_q == tcrs_pkg::SIC_OFF) begin
			posted_q <= PWDATA[tcrs_pkg::POSTED_BIT];
			rdmode_q <= PWDATA[tcrs_pkg::RDMODE_BIT];
		end else if (wr_acc && addr_q == tcrs_pkg::CTL_OFF) begin
			run_q <= PWDATA[tcrs_pkg::RUN_BIT];
		end
	end

	// stale flag out on a pin for the power manager
	always_ff @(posedge MCLK) begin
		if (SRST) TIMER_STALE <= 1'b1;
		else TIMER_STALE <= (st_d != tcrs_pkg::TCRS_SYNCED);
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);

	a_rdmode_reads_zero: assert property (PREADY && !wr_q && addr_q == tcrs_pkg::SIC_OFF
		&& RDMODE_WO |-> !PRDATA[tcrs_pkg::RDMODE_BIT]) else $error("read mode bit read back");
	a_live_counter_read: assert property (PSEL && !PENABLE && !PWRITE
		&& PADDR == tcrs_pkg::TCV_OFF && live_rd |=> PRDATA == tcrs_ext($past(tmr_cnt_q)))
		else $error("live read wrong");
	a_posted_copy_read: assert property (PSEL && !PENABLE && !PWRITE
		&& PADDR == tcrs_pkg::TCV_OFF && posted_q |=> PRDATA == tcrs_ext($past(tmr_cp_q)))
		else $error("posted read not from copy");
	a_wdog_copy_read: assert property (PSEL && !PENABLE && !PWRITE
		&& PADDR == tcrs_pkg::WCV_OFF |=> PRDATA == tcrs_ext($past(wd_cp_q)))
		else $error("watchdog read not deferred");
	a_copy_frozen_idle: assert property (st_q == tcrs_pkg::TCRS_SLEEP |=> $stable(wd_cp_q))
		else $error("copy moved while interface stopped");
	a_resume_wait_two: assert property (st_q == tcrs_pkg::TCRS_SLEEP && act_rise
		|=> (st_q == tcrs_pkg::TCRS_WAITIF)[*2]) else $error("resume wait too short");
	a_stale_ends_tick: assert property (st_q == tcrs_pkg::TCRS_WAITFN && tick && act_s_q
		|=> st_q == tcrs_pkg::TCRS_SYNCED ##1 !TIMER_STALE) else $error("stale not cleared");
	a_sic_keeps_wdog: assert property (wr_acc && addr_q == tcrs_pkg::SIC_OFF
		|=> wd_cnt_q == $past(wd_cnt_q) + CW'(($past(tick)) ? 1 : 0))
		else $error("mode write touched watchdog");
	a_ready_one_cycle: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
		else $error("ready timing wrong");
endmodule : tcrs_timer
